//--- verilog/tmw_pkg.sv
// thermal watchdog package: register pointers, reset values, config layout,
// bus states and timing counts.
// assumes a single 40 MHz system clock shared by every user of these constants.
package tmw_pkg;

  // ----------------------------------------------------------------------
  // register pointers
  // ----------------------------------------------------------------------
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CONF = 3'h1;
  localparam logic [2:0] PTR_THYST = 3'h2;
  localparam logic [2:0] PTR_TOS = 3'h3;
  localparam logic [2:0] PTR_IDLE = 3'h4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [15:0] TOS_RST = 16'h5000;   // 80.0 degC, 9 bits left aligned
  localparam logic [15:0] THYST_RST = 16'h4b00; // 75.0 degC
  localparam logic [4:0] IDLE_RST = 5'h01;
  localparam logic TIMEOUT_EN_RST = 1'b1;

  // ----------------------------------------------------------------------
  // fault queue lengths per trip_count_select code
  // ----------------------------------------------------------------------
  localparam logic [2:0] TRIP_N0 = 3'h1;
  localparam logic [2:0] TRIP_N1 = 3'h2;
  localparam logic [2:0] TRIP_N2 = 3'h4;
  localparam logic [2:0] TRIP_N3 = 3'h6;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned TO_W = 20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // configuration register layout, top bit first
  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] trip_count_select;
    logic alarm_polarity;
    logic alarm_latch_select;
    logic shutdown;
  } tmw_cfg_t;

  // serial slave states, gray steps along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_WBYTE = 3'b010,
    ST_WACK = 3'b110,
    ST_RBYTE = 3'b111,
    ST_RACK = 3'b101
  } tmw_state_t;

endpackage

//--- verilog/tmw_alarm.sv
// alarm decision: fault queue, comparator and latched modes.
// assumes conv_ok is a one-cycle pulse on sys_clk and rd_evt a one-cycle pulse.
`timescale 1ns/1ps
module tmw_alarm import tmw_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // conversion result
  input wire logic conv_ok,
  input wire logic [8:0] temp9,
  // limits and settings
  input wire logic [8:0] tos9,
  input wire logic [8:0] thyst9,
  input wire tmw_cfg_t cfg,
  // bus read event
  input wire logic rd_evt,
  // alarm state, asserted high
  output logic alarm_act
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] trip_need(input logic [1:0] sel);
    case (sel)
      2'h0: trip_need = TRIP_N0;
      2'h1: trip_need = TRIP_N1;
      2'h2: trip_need = TRIP_N2;
      default: trip_need = TRIP_N3;
    endcase
  endfunction

  logic dir_q;       // 0 waits for hot, 1 waits for cold
  logic [2:0] cnt_q;
  logic [1:0] qsel_q;
  logic shut_q;
  logic alarm_q;

  // 9-bit signed compare, only upper result bits reach here
  wire hot = $signed(temp9) > $signed(tos9);
  wire cold = $signed(temp9) < $signed(thyst9);
  wire trip = dir_q ? cold : hot;
  wire [2:0] need = trip_need(cfg.trip_count_select);
  wire fire = conv_ok && trip && ((cnt_q + 3'h1) == need);
  wire qchg = cfg.trip_count_select != qsel_q;
  wire shut_enter = cfg.shutdown && !shut_q;
  wire clr = cfg.alarm_latch_select && (rd_evt || shut_enter);
  // a fresh fire beats a same-cycle clear so no event is lost
  wire alarm_d = fire ? (cfg.alarm_latch_select || !dir_q) : (clr ? 1'b0 : alarm_q);
  wire cnt_clr = qchg || (conv_ok && !trip) || fire;
  wire [2:0] cnt_d = cnt_clr ? 3'h0 : (conv_ok ? cnt_q + 3'h1 : cnt_q);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dir_q <= 1'b0;
      cnt_q <= 3'h0;
      qsel_q <= 2'h0;
      shut_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      dir_q <= fire ? !dir_q : dir_q;
      cnt_q <= cnt_d;
      qsel_q <= cfg.trip_count_select;
      shut_q <= cfg.shutdown;
      alarm_q <= alarm_d;
    end
  end

  assign alarm_act = alarm_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  alarm_on_conv_a: assert property ($rose(alarm_q) |-> $past(conv_ok))
    else $error("alarm rose without a conversion end");
  queue_count_a: assert property (!qchg |-> cnt_q < need)
    else $error("trip counter ran past the queue length");
  count_restart_a: assert property (conv_ok && !trip |=> cnt_q == 3'h0)
    else $error("trip counter not restarted");
  latch_hold_a: assert property (cfg.alarm_latch_select && alarm_q && !clr |=> alarm_q)
    else $error("latched alarm dropped without a read");
  comp_read_a: assert property (!cfg.alarm_latch_select && !conv_ok && (rd_evt || shut_enter)
      |=> alarm_q == $past(alarm_q))
    else $error("comparator alarm changed on read or shutdown");
  shut_clear_a: assert property (cfg.alarm_latch_select && shut_enter && !fire |=> !alarm_q)
    else $error("latched alarm not cleared on shutdown");
  one_trip_a: assert property (conv_ok && trip && cnt_q == 3'h0 && need == TRIP_N0 && !qchg
      |=> alarm_q == (cfg.alarm_latch_select || !$past(dir_q)))
    else $error("single trip did not set alarm");

  cover_latch_c: cover property (cfg.alarm_latch_select && $rose(alarm_q));
  cover_comp_c: cover property (!cfg.alarm_latch_select && $fell(alarm_q));
  cover_six_c: cover property (fire && need == TRIP_N3);

endmodule

//--- verilog/tmw_top.sv
// thermal watchdog: serial register slave, register file, shutdown gating
// and open-drain alarm pin.
// assumes the converter sits on sys_clk and pulses conv_done with a result;
// serial lines and address straps arrive asynchronously.
//
// Behaviour
// - polarity bit chooses alarm asserted level
// - polarity resets to zero, active low
// - mode bit selects latched or comparator
// - mode bit resets to comparator
// - comparator: set above high, clear below hysteresis
// - latched: set on event, cleared by read
// - evaluate at conversion end, consecutive trips
// - queue codes map to 1,2,4,6 trips
// - queue resets to code zero, one trip
// - shutdown bit stops or resumes conversion
// - shutdown halts conversion, bus stays alive
// - shutdown clears latched alarm, keeps comparator
// - reset values for limits, pointer, timeout
// - device pulls data low to acknowledge
// - host acknowledge requests second byte
// - final slot not acknowledged, then stop
// - one-byte read is accepted
// - compare nine upper temperature bits
// - limits nine bits, left aligned
`timescale 1ns/1ps
module tmw_top import tmw_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // address straps
  input wire logic [6:0] dev_addr,
  // converter side
  input wire logic conv_done,
  input wire logic [10:0] conv_temp,
  output logic conv_run,
  output logic [4:0] conv_period,
  // alarm pin
  output logic alarm_o,
  output logic alarm_oe
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [6:0] addr_m_q, addr_s_q;

  // two flops first, the third only feeds edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      addr_m_q <= 7'h00;
      addr_s_q <= 7'h00;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      addr_m_q <= dev_addr;
      addr_s_q <= addr_m_q;
    end
  end

  // bus events, data read at scl rise since host holds it while high
  wire scl_rise = scl_s_q && !scl_p_q;
  wire scl_fall = !scl_s_q && scl_p_q;
  wire start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  wire stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [2:0] ptr_q;
  tmw_cfg_t cfg_q;
  logic [15:0] temp_q, tos_q, thyst_q;
  logic [4:0] idle_q;
  logic timeout_en_q;

  function automatic logic [7:0] rd_byte(input logic [2:0] p, input logic lsb,
      input logic [15:0] t, input logic [7:0] c, input logic [15:0] h,
      input logic [15:0] o, input logic [4:0] i);
    case (p)
      PTR_TEMP: rd_byte = lsb ? t[7:0] : t[15:8];
      PTR_CONF: rd_byte = c;
      PTR_THYST: rd_byte = lsb ? h[7:0] : h[15:8];
      PTR_TOS: rd_byte = lsb ? o[7:0] : o[15:8];
      PTR_IDLE: rd_byte = {3'h0, i};
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------------
  tmw_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] idx_q, idx_d;
  logic rw_q, rw_d;
  logic sda_oe_q, sda_oe_d;
  logic rd_evt, wr_evt;
  logic [TO_W-1:0] to_q;

  wire timeout = timeout_en_q && (to_q == TO_W'(TIMEOUT_CYCLES - 1));
  wire [7:0] first_byte = rd_byte(ptr_q, 1'b0, temp_q, cfg_q, thyst_q, tos_q, idle_q);
  wire [7:0] next_byte = rd_byte(ptr_q, idx_q[0], temp_q, cfg_q, thyst_q, tos_q, idle_q);
  wire bits_full = bit_q == BITS_PER_BYTE;

  // next-state for the byte engine; host supplies every clock pulse
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    idx_d = idx_q;
    rw_d = rw_q;
    sda_oe_d = sda_oe_q;
    rd_evt = 1'b0;
    wr_evt = 1'b0;
    if (stop_det || timeout) begin
      st_d = ST_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_det) begin
      st_d = ST_ADDR;
      bit_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise && !bits_full) begin
            sh_d = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bits_full) begin
            if (st_q == ST_WBYTE) begin
              st_d = ST_WACK;
              sda_oe_d = 1'b1;
              wr_evt = 1'b1;
            end else if (sh_q[7:1] == addr_s_q) begin
              st_d = ST_AACK;
              sda_oe_d = 1'b1;
              rw_d = sh_q[0];
              idx_d = 2'h0;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall && rw_q) begin
            st_d = ST_RBYTE;
            sh_d = first_byte;
            sda_oe_d = !first_byte[7];
            bit_d = 4'h1;
            idx_d = 2'h1;
            rd_evt = 1'b1;
          end else if (scl_fall) begin
            st_d = ST_WBYTE;
            sda_oe_d = 1'b0;
            bit_d = 4'h0;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            st_d = ST_WBYTE;
            sda_oe_d = 1'b0;
            bit_d = 4'h0;
            idx_d = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
          end
        end
        ST_RBYTE: begin
          if (scl_fall && bits_full) begin
            st_d = ST_RACK;
            sda_oe_d = 1'b0;
          end else if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            sda_oe_d = !sh_q[6];
            bit_d = bit_q + 4'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise && bits_full) begin
            // released line means the host is done, wait for stop
            st_d = sda_s_q ? ST_IDLE : ST_RACK;
            bit_d = 4'h0;
          end else if (scl_fall && !bits_full) begin
            st_d = ST_RBYTE;
            sh_d = next_byte;
            sda_oe_d = !next_byte[7];
            bit_d = 4'h1;
            idx_d = idx_q + 2'h1;
          end
        end
        default: begin
          st_d = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // byte engine flops; reads and writes stay alive in shutdown
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // stuck-low clock watchdog frees the bus instead of hanging it
  always_ff @(posedge sys_clk) begin
    if (srst || st_q == ST_IDLE || scl_s_q) begin
      to_q <= '0;
    end else if (!timeout) begin
      to_q <= to_q + TO_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // register writes and conversion capture
  // ----------------------------------------------------------------------
  wire conv_ok = conv_done && !cfg_q.shutdown;
  wire wr_ptr = wr_evt && idx_q == 2'h0;
  wire wr_msb = wr_evt && idx_q == 2'h1;
  wire wr_lsb = wr_evt && idx_q == 2'h2;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_q <= PTR_RST;
      cfg_q <= tmw_cfg_t'(CONF_RST);
      temp_q <= 16'h0000;
      tos_q <= TOS_RST;
      thyst_q <= THYST_RST;
      idle_q <= IDLE_RST;
      timeout_en_q <= TIMEOUT_EN_RST;
    end else begin
      if (wr_ptr) ptr_q <= sh_q[2:0];
      if (wr_msb && ptr_q == PTR_CONF) cfg_q <= tmw_cfg_t'({3'h0, sh_q[4:0]});
      if (wr_msb && ptr_q == PTR_IDLE) idle_q <= sh_q[4:0];
      if (wr_msb && ptr_q == PTR_TOS) tos_q[15:8] <= sh_q;
      if (wr_lsb && ptr_q == PTR_TOS) tos_q[7:0] <= {sh_q[7], 7'h00};
      if (wr_msb && ptr_q == PTR_THYST) thyst_q[15:8] <= sh_q;
      if (wr_lsb && ptr_q == PTR_THYST) thyst_q[7:0] <= {sh_q[7], 7'h00};
      if (conv_ok) temp_q <= {conv_temp, 5'h00};
    end
  end

  // ----------------------------------------------------------------------
  // alarm
  // ----------------------------------------------------------------------
  logic alarm_act;
  logic conv_run_q, alarm_oe_q;
  logic [4:0] period_q;

  tmw_alarm u_alarm (
    .sys_clk(sys_clk),
    .srst(srst),
    .conv_ok(conv_ok),
    .temp9(temp_q[15:7]),
    .tos9(tos_q[15:7]),
    .thyst9(thyst_q[15:7]),
    .cfg(cfg_q),
    .rd_evt(rd_evt),
    .alarm_act(alarm_act)
  );

  // pin level is the polarity when asserted; low level means pulling down
  wire pin_level = alarm_act ? cfg_q.alarm_polarity : !cfg_q.alarm_polarity;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_run_q <= 1'b0;
      period_q <= IDLE_RST;
      alarm_oe_q <= 1'b0;
    end else begin
      conv_run_q <= !cfg_q.shutdown;
      period_q <= idle_q;
      alarm_oe_q <= !pin_level;
    end
  end

  assign sda_o = 1'b0;
  assign alarm_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign alarm_oe = alarm_oe_q;
  assign conv_run = conv_run_q;
  assign conv_period = period_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  pin_polarity_a: assert property (##1 alarm_oe_q ==
      ($past(alarm_act) ? !$past(cfg_q.alarm_polarity) : $past(cfg_q.alarm_polarity)))
    else $error("alarm pin level wrong for polarity");
  reset_values_a: assert property ($past(srst) |-> cfg_q == tmw_cfg_t'(CONF_RST)
      && ptr_q == PTR_RST && tos_q == TOS_RST && thyst_q == THYST_RST)
    else $error("register reset values wrong");
  shutdown_halt_a: assert property (cfg_q.shutdown |-> !conv_ok ##1 !conv_run_q)
    else $error("conversion ran in shutdown");
  addr_ack_a: assert property (st_q == ST_AACK |-> sda_oe_q)
    else $error("address acknowledge not driven");
  release_ack_a: assert property (st_q == ST_RACK |-> !sda_oe_q)
    else $error("device drove line in host acknowledge slot");

  cover_read_c: cover property (st_q == ST_RACK ##[1:400] st_q == ST_RBYTE);
  cover_write_c: cover property (wr_lsb && ptr_q == PTR_TOS);

endmodule

//--- dv/tmw_host_bfm.sv
// serial host model for the thermal watchdog bench: framing, byte transfers, acks.
// assumes the bench resolves the open-drain data wire and pulls it up; the clock is driven both ways.
`timescale 1ns/1ps
module tmw_host_bfm import tmw_pkg::*; (
  // clock
  input wire logic sys_clk,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_oe,
  // read result, one-cycle strobe
  output logic rd_stb,
  output logic [16:0] rd_val
);
  logic nak;

  // both lines released at start, so the bus is idle
  initial begin
    scl <= 1'b1;
    sda_oe <= 1'b0;
    rd_stb <= 1'b0;
    rd_val <= '0;
    nak = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one 200 ns pulse; data moves late in the low phase to stay clear of the slave sync
  task automatic bit_io(input logic b, output logic s);
    w(3);
    sda_oe <= ~b;
    w(1);
    scl <= 1'b1;
    w(3);
    s = sda_line;
    w(1);
    scl <= 1'b0;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_c();
    w(3);
    sda_oe <= 1'b0;
    w(1);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b1;
    w(4);
    scl <= 1'b0;
  endtask

  // stop: data rises while the clock is high, bus is free after it
  task automatic stop_c();
    w(3);
    sda_oe <= 1'b1;
    w(1);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b0;
    w(4);
  endtask

  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    nak = nak | s;
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [2:0] p, input int nb,
                           input logic [15:0] d);
    nak = 1'b0;
    start_c();
    wr_byte({a, 1'b0});
    wr_byte({5'h00, p});
    if (nb > 0) wr_byte(d[15:8]);
    if (nb > 1) wr_byte(d[7:0]);
    stop_c();
  endtask

  // read, optionally setting the pointer first; posts {nak seen, data}
  task automatic read_reg(input logic [6:0] a, input logic [2:0] p, input logic set_p,
                          input int nb);
    logic [15:0] d;
    nak = 1'b0;
    d = '0;
    if (set_p) begin
      start_c();
      wr_byte({a, 1'b0});
      wr_byte({5'h00, p});
    end
    start_c();
    wr_byte({a, 1'b1});
    rd_byte(nb == 1, d[15:8]);
    if (nb > 1) rd_byte(1'b1, d[7:0]);
    stop_c();
    rd_val <= {nak, d};
    rd_stb <= 1'b1;
    w(1);
    rd_stb <= 1'b0;
  endtask
endmodule

//--- dv/testbench.sv
// self-checking bench for the thermal watchdog: reset values, fault queue, polarity,
// comparator and latched alarm, shutdown, serial reads.
// assumes the host model in dv/tmw_host_bfm.sv and pull-ups on data and alarm lines.
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end
module testbench import tmw_pkg::*; ;
  localparam logic [10:0] T_MID = 11'h283; // 80.375 degC, top nine bits equal the limit
  logic sys_clk, srst, conv_done, scl, h_oe, sda_line, obs_stb, rd_stb;
  logic sda_o, sda_oe, conv_run, alarm_o, alarm_oe, alarm_pin;
  logic [10:0] conv_temp;
  logic [6:0] dev_addr, addr, e_obs;
  logic [4:0] conv_period;
  logic [16:0] rd_val, e_rd;
  logic [16:0] rd_q[$];
  logic [6:0] obs_q[$];
  int err_total, n_tests;
  tmw_cfg_t cfg;

  // open-drain lines with pull-ups
  assign sda_line = ~(h_oe | (sda_oe & ~sda_o));
  assign alarm_pin = alarm_oe ? alarm_o : 1'b1;

  tmw_top #(.TIMEOUT_CYCLES(200)) dut (
    .sys_clk(sys_clk), .srst(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .conv_done(conv_done), .conv_temp(conv_temp),
    .conv_run(conv_run), .conv_period(conv_period), .alarm_o(alarm_o),
    .alarm_oe(alarm_oe));

  tmw_host_bfm host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_oe(h_oe),
    .rd_stb(rd_stb), .rd_val(rd_val));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // result watcher: oldest note against what appears
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rd_stb) begin
      e_rd = rd_q.pop_front();
      `CHK("read_data", e_rd, rd_val)
    end
    if (obs_stb) begin
      e_obs = obs_q.pop_front();
      `CHK("run_period_pin", e_obs, {conv_run, conv_period, alarm_pin})
    end
  end

  task automatic final_report();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // converter results; each pulse makes the alarm judge the result loaded before it
  task automatic feed(input logic [10:0] t, input int n);
    repeat (n) begin
      conv_temp <= t;
      conv_done <= 1'b1;
      tick(1);
      conv_done <= 1'b0;
      tick(3);
    end
  endtask

  // note run flag, idle period and pin level expected for an alarm state
  task automatic expect_obs(input logic act);
    obs_q.push_back({~cfg.shutdown, IDLE_RST, act ? cfg.alarm_polarity : ~cfg.alarm_polarity});
    obs_stb <= 1'b1;
    tick(1);
    obs_stb <= 1'b0;
  endtask

  task automatic set_cfg(input logic [1:0] qs, input logic pol, input logic lat,
                         input logic sd);
    cfg = {3'h0, qs, pol, lat, sd};
    host.write_reg(addr, PTR_CONF, 1, {cfg, 8'h00});
  endtask

  // a one-byte read of the configuration, which also counts as a register read
  task automatic chk_cfg();
    rd_q.push_back({1'b0, cfg, 8'h00});
    host.read_reg(addr, PTR_CONF, 1'b1, 1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    logic [10:0] hot, cold;
    logic [15:0] lim;
    void'($urandom(32'hbceac537));
    addr = 7'h48 | 7'($urandom_range(7, 0));
    srst <= 1'b1;
    conv_done <= 1'b0;
    conv_temp <= 11'h000;
    obs_stb <= 1'b0;
    dev_addr <= addr;
    err_total = 0;
    n_tests = 0;
    cfg = CONF_RST;
    tick(2);
    srst <= 1'b0;
    tick(6);
    // power-up state, pointer preset to temperature
    expect_obs(1'b0);
    rd_q.push_back(17'h00000);
    host.read_reg(addr, PTR_TEMP, 1'b0, 1);
    chk_cfg();
    rd_q.push_back({1'b0, TOS_RST});
    host.read_reg(addr, PTR_TOS, 1'b1, 2);
    rd_q.push_back({1'b0, THYST_RST});
    host.read_reg(addr, PTR_THYST, 1'b1, 2);
    // another address is not acknowledged and leaves the line released
    rd_q.push_back({1'b1, 16'hff00});
    host.read_reg(addr ^ 7'h01, PTR_CONF, 1'b1, 1);
    // every queue code, both polarities; a miss in mid-run restarts the count
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : (c == 1) ? 2 : (c == 2) ? 4 : 6;
      hot = 11'h284 + 11'($urandom_range(300, 0));
      cold = 11'($urandom_range(11'h257, 0));
      set_cfg(2'(c), c[0], 1'b0, 1'b0);
      feed(cold, 8);
      expect_obs(1'b0);
      feed(hot, n - 1);
      feed(T_MID, 1);
      feed(hot, 1);
      feed(hot, n - 1);
      expect_obs(1'b0);
      feed(hot, 1);
      expect_obs(1'b1);
    end
    // comparator: reads and shutdown keep the alarm, results ignored in shutdown
    chk_cfg();
    expect_obs(1'b1);
    set_cfg(2'h3, 1'b1, 1'b0, 1'b1);
    feed(cold, 8);
    expect_obs(1'b1);
    chk_cfg();
    set_cfg(2'h0, 1'b0, 1'b0, 1'b0);
    feed(cold, 8);
    expect_obs(1'b0);
    // latched mode: hot event, read clear, cold event, shutdown clear
    set_cfg(2'h0, 1'b0, 1'b1, 1'b0);
    feed(hot, 2);
    expect_obs(1'b1);
    chk_cfg();
    expect_obs(1'b0);
    feed(hot, 3);
    expect_obs(1'b0);
    feed(cold, 2);
    expect_obs(1'b1);
    set_cfg(2'h0, 1'b0, 1'b1, 1'b1);
    expect_obs(1'b0);
    // limit and idle writes in shutdown; limit kept above hysteresis, lsb keeps one bit
    lim = {8'(8'h4c + 8'($urandom_range(50, 0))), 8'($urandom())};
    host.write_reg(addr, PTR_TOS, 2, lim);
    rd_q.push_back({1'b0, lim[15:7], 7'h00});
    host.read_reg(addr, PTR_TOS, 1'b1, 2);
    host.write_reg(addr, PTR_IDLE, 1, {3'h0, lim[4:0], 8'h00});
    rd_q.push_back({1'b0, 3'h0, lim[4:0], 8'h00});
    host.read_reg(addr, PTR_IDLE, 1'b1, 1);
    // second reset from shutdown and latched mode
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(6);
    cfg = CONF_RST;
    expect_obs(1'b0);
    chk_cfg();
    // the reset brings the written limit back to its default
    rd_q.push_back({1'b0, TOS_RST});
    host.read_reg(addr, PTR_TOS, 1'b1, 2);
    tick(4);
    final_report();
  end
endmodule
